// file: rtl/ncad_pkg.sv
// Package: command codes, bus timing and request types for the NAND host sequencer
package ncad_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_MHZ    = 100;
  localparam int T_CLS_NS   = 12;
  localparam int T_WP_NS    = 12;
  localparam int T_WH_NS    = 10;
  localparam int T_ADL_NS   = 100;
  localparam int T_RP_NS    = 30;
  localparam int T_REH_NS   = 10;
  localparam int T_WB_NS    = 100;
  localparam int T_CLS_CYC  = (T_CLS_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WP_CYC   = (T_WP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WH_CYC   = (T_WH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_ADL_CYC  = (T_ADL_NS * CLK_MHZ + 999) / 1000;
  localparam int T_RP_CYC   = (T_RP_NS * CLK_MHZ + 999) / 1000;
  localparam int T_REH_CYC  = (T_REH_NS * CLK_MHZ + 999) / 1000;
  localparam int T_WB_CYC   = (T_WB_NS * CLK_MHZ + 999) / 1000;

  // ==========================================================
  // Geometry
  localparam logic [11:0] PAGE_BYTES = 12'h840;
  localparam logic [11:0] SPARE_COL  = 12'h800;

  // ==========================================================
  // Command bytes
  localparam logic [7:0] CMD_READ      = 8'h00;
  localparam logic [7:0] CMD_READ_GO   = 8'h30;
  localparam logic [7:0] CMD_CB_READ   = 8'h35;
  localparam logic [7:0] CMD_READ_ID   = 8'h90;
  localparam logic [7:0] CMD_RESET     = 8'hFF;
  localparam logic [7:0] CMD_UNLOCK_LO = 8'h23;
  localparam logic [7:0] CMD_UNLOCK_HI = 8'h24;
  localparam logic [7:0] CMD_LOCK      = 8'h2A;
  localparam logic [7:0] CMD_LOCK_T    = 8'h2C;
  localparam logic [7:0] CMD_LOCK_STAT = 8'h7A;
  localparam logic [7:0] CMD_PROG      = 8'h80;
  localparam logic [7:0] CMD_PROG_GO   = 8'h10;
  localparam logic [7:0] CMD_CB_PROG   = 8'h85;
  localparam logic [7:0] CMD_ERASE     = 8'h60;
  localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
  localparam logic [7:0] CMD_RAND_OUT  = 8'h05;
  localparam logic [7:0] CMD_RAND_GO   = 8'hE0;
  localparam logic [7:0] CMD_STATUS    = 8'h70;
  localparam logic [7:0] CMD_CACHE_GO  = 8'h15;
  localparam logic [7:0] CMD_CACHE_RD  = 8'h31;
  localparam logic [7:0] CMD_CACHE_END = 8'h3F;

  // ==========================================================
  // Types
  typedef enum logic [4:0] {
    OP_READ = 5'h00, OP_CB_READ = 5'h01, OP_READ_ID = 5'h02, OP_RESET = 5'h03,
    OP_UNLOCK = 5'h04, OP_LOCK = 5'h05, OP_LOCK_TIGHT = 5'h06, OP_LOCK_STAT = 5'h07,
    OP_PROG = 5'h08, OP_CB_PROG = 5'h09, OP_ERASE = 5'h0A, OP_RAND_IN = 5'h0B,
    OP_RAND_OUT = 5'h0C, OP_STATUS = 5'h0D, OP_CACHE_PROG = 5'h0E,
    OP_CACHE_READ = 5'h0F, OP_CACHE_LAST = 5'h10
  } ncad_op_e;

  typedef enum logic [2:0] {
    AK_NONE = 3'h0, AK_ONE = 3'h1, AK_COL2 = 3'h2, AK_ROW2 = 3'h3, AK_FULL = 3'h4
  } ncad_addr_e;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0, ST_CMD1 = 4'h1, ST_ADDR = 4'h2, ST_GAP = 4'h3, ST_WDATA = 4'h4,
    ST_CMD2 = 4'h5, ST_ADDR2 = 4'h6, ST_WAITB = 4'h7, ST_BUSY = 4'h8,
    ST_RDATA = 4'h9, ST_DONE = 4'hA
  } ncad_st_e;

  typedef enum logic [1:0] {
    BC_IDLE = 2'b00, BC_SETUP = 2'b01, BC_LOW = 2'b10, BC_HIGH = 2'b11
  } ncad_bc_e;

  typedef struct packed {
    ncad_op_e    op;
    logic [11:0] col;
    logic [9:0]  block;
    logic [5:0]  page;
    logic [9:0]  block_end;
    logic [11:0] len;
  } ncad_req_s;

  typedef struct packed {
    logic [7:0] cmd1;
    logic       has_cmd2;
    logic [7:0] cmd2;
    ncad_addr_e ak;
    logic       addr2;
    logic       wr;
    logic       rd;
    logic       waitb;
    logic       busy_ok;
  } ncad_info_s;

  typedef struct packed {
    logic       rd;
    logic       cle;
    logic       ale;
    logic [7:0] data;
  } ncad_cyc_s;

  function automatic ncad_info_s ncad_op_info(input ncad_op_e op);
    ncad_info_s i;
    i = '{CMD_STATUS, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    case (op)
      OP_READ:       i = '{CMD_READ, 1'b1, CMD_READ_GO, AK_FULL, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      OP_CB_READ:    i = '{CMD_READ, 1'b1, CMD_CB_READ, AK_FULL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      OP_READ_ID:    i = '{CMD_READ_ID, 1'b0, CMD_READ, AK_ONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      OP_RESET:      i = '{CMD_RESET, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
      OP_UNLOCK:     i = '{CMD_UNLOCK_LO, 1'b1, CMD_UNLOCK_HI, AK_ROW2, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_LOCK:       i = '{CMD_LOCK, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_LOCK_TIGHT: i = '{CMD_LOCK_T, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
      OP_LOCK_STAT:  i = '{CMD_LOCK_STAT, 1'b0, CMD_READ, AK_ROW2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      OP_PROG:       i = '{CMD_PROG, 1'b1, CMD_PROG_GO, AK_FULL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      OP_CB_PROG:    i = '{CMD_CB_PROG, 1'b1, CMD_PROG_GO, AK_FULL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      OP_ERASE:      i = '{CMD_ERASE, 1'b1, CMD_ERASE_GO, AK_ROW2, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0};
      OP_RAND_IN:    i = '{CMD_CB_PROG, 1'b0, CMD_READ, AK_COL2, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0};
      OP_RAND_OUT:   i = '{CMD_RAND_OUT, 1'b1, CMD_RAND_GO, AK_COL2, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
      OP_STATUS:     i = '{CMD_STATUS, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};
      OP_CACHE_PROG: i = '{CMD_PROG, 1'b1, CMD_CACHE_GO, AK_FULL, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
      OP_CACHE_READ: i = '{CMD_CACHE_RD, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      OP_CACHE_LAST: i = '{CMD_CACHE_END, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0};
      default:       i = '{CMD_STATUS, 1'b0, CMD_READ, AK_NONE, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
    endcase
    return i;
  endfunction : ncad_op_info

endpackage : ncad_pkg

// file: rtl/ncad_bus_cycle.sv
// Bus cycle engine: one command, address, data-in or data-out cycle on the NAND pins
`timescale 1ns/10ps
module ncad_bus_cycle
  import ncad_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       start,
  input  wire ncad_cyc_s  cyc,
  input  wire logic       sel,
  input  wire logic [7:0] nand_io_i,
  output logic            nand_ce_n,
  output logic            nand_cle,
  output logic            nand_ale,
  output logic            nand_we_n,
  output logic            read_strobe_n,
  output logic [7:0]      nand_io_o,
  output logic            nand_io_oe,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            done
);

  ncad_bc_e   st_q, st_d;
  logic [3:0] cnt_q, cnt_d;
  logic       rd_q, rd_d, ce_n_d, cle_d, ale_d, we_n_d, re_n_d, oe_d, rvld_d, done_d;
  logic [7:0] io_d, rdat_d;

  // ==========================================================
  // Next state
  always_comb begin
    st_d   = st_q;
    cnt_d  = cnt_q;
    rd_d   = rd_q;
    ce_n_d = ~sel;
    cle_d  = nand_cle;
    ale_d  = nand_ale;
    we_n_d = nand_we_n;
    re_n_d = read_strobe_n;
    io_d   = nand_io_o;
    oe_d   = nand_io_oe;
    rdat_d = rd_data;
    rvld_d = 1'b0;
    done_d = 1'b0;
    case (st_q)
      BC_IDLE: if (start) begin
        rd_d  = cyc.rd;
        cle_d = cyc.cle;
        ale_d = cyc.ale;
        io_d  = cyc.data;
        oe_d  = ~cyc.rd;
        if (cyc.rd) begin
          re_n_d = 1'b0;
          cnt_d  = 4'(T_RP_CYC - 1);
          st_d   = BC_LOW;
        end else begin
          cnt_d = 4'(T_CLS_CYC - 1);
          st_d  = BC_SETUP;
        end
      end
      BC_SETUP: if (cnt_q == 4'h0) begin
        we_n_d = 1'b0;
        cnt_d  = 4'(T_WP_CYC - 1);
        st_d   = BC_LOW;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      BC_LOW: if (cnt_q == 4'h0) begin
        we_n_d = 1'b1;
        re_n_d = 1'b1;
        st_d   = BC_HIGH;
        if (rd_q) begin
          rdat_d = nand_io_i;
          rvld_d = 1'b1;
          cnt_d  = 4'(T_REH_CYC - 1);
        end else begin
          cnt_d = 4'(T_WH_CYC - 1);
        end
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      BC_HIGH: if (cnt_q == 4'h0) begin
        // Latch selects held past the rising strobe for hold time
        cle_d  = 1'b0;
        ale_d  = 1'b0;
        oe_d   = 1'b0;
        done_d = 1'b1;
        st_d   = BC_IDLE;
      end else begin
        cnt_d = cnt_q - 4'h1;
      end
      default: st_d = BC_IDLE;
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= BC_IDLE;
      cnt_q <= 4'h0;
      rd_q <= 1'b0;
      nand_ce_n <= 1'b1;
      nand_cle <= 1'b0;
      nand_ale <= 1'b0;
      nand_we_n <= 1'b1;
      read_strobe_n <= 1'b1;
      nand_io_o <= 8'h00;
      nand_io_oe <= 1'b0;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      done <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      rd_q <= rd_d;
      nand_ce_n <= ce_n_d;
      nand_cle <= cle_d;
      nand_ale <= ale_d;
      nand_we_n <= we_n_d;
      read_strobe_n <= re_n_d;
      nand_io_o <= io_d;
      nand_io_oe <= oe_d;
      rd_data <= rdat_d;
      rd_valid <= rvld_d;
      done <= done_d;
    end
  end

  // ==========================================================
  // Checks
  property p_we_width;
    @(posedge clk) disable iff (sys_rst) $fell(nand_we_n) |=> !nand_we_n ##1 nand_we_n;
  endproperty
  a_we_width: assert property (p_we_width) else $error("write strobe width wrong");

  property p_re_sample;
    @(posedge clk) disable iff (sys_rst) $fell(read_strobe_n) |-> ##3 (rd_valid && read_strobe_n);
  endproperty
  a_re_sample: assert property (p_re_sample) else $error("read byte not taken");

endmodule : ncad_bus_cycle

// file: rtl/ncad_host.sv
// NAND host sequencer: turns operation requests into command/address/data bus cycles
//
// Behaviour
// - Row bytes carry page in A12-A17 and block in A18-A27, cycles three and four of a full address, one and two of a row-only address.
// - Second column address cycle drives the upper four bus lines low.
// - Each byte is taken on the write strobe rising edge with chip select low.
// - Command latch high marks commands, address latch high addresses, both low data.
// - Two-cycle commands send setup byte, then execution byte that starts the operation.
`timescale 1ns/10ps
module ncad_host
  import ncad_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       req_valid,
  input  wire ncad_req_s  req,
  output logic            req_ready,
  output logic            req_ack,
  input  wire logic [7:0] wr_data,
  input  wire logic       wr_valid,
  output logic            wr_ack,
  output logic [7:0]      rd_data,
  output logic            rd_valid,
  output logic            op_done,
  output logic            nand_ce_n,
  output logic            nand_cle,
  output logic            nand_ale,
  output logic            nand_we_n,
  output logic            read_strobe_n,
  output logic            nand_wp_n,
  output logic [7:0]      nand_io_o,
  output logic            nand_io_oe,
  input  wire logic [7:0] nand_io_i,
  input  wire logic       nand_rb
);

  ncad_st_e    st_q, st_d, nxt_busy, nxt_cmd2, nxt_addr;
  ncad_req_s   req_q, req_d;
  ncad_info_s  info_q, info_d, info_in;
  ncad_cyc_s   cyc;
  logic        pend_q, pend_d, start, bc_done, cyc_st, acc_ok;
  logic        rdy_d, ack_d, wack_d, done_d;
  logic [1:0]  idx_q, idx_d, last_idx;
  logic [11:0] left_q, left_d;
  logic [3:0]  wait_q, wait_d;
  logic [15:0] row, row_end;

  assign info_in = ncad_op_info(req.op);
  // Busy device only takes commands it can answer mid-operation
  assign acc_ok  = nand_rb || info_in.busy_ok;
  assign row     = {req_q.block, req_q.page};
  assign row_end = {req_q.block_end, 6'h00};
  assign last_idx = (info_q.ak == AK_FULL) ? 2'd3 : (info_q.ak == AK_ONE) ? 2'd0 : 2'd1;

  // ==========================================================
  // Sequencer
  always_comb begin
    st_d   = st_q;
    req_d  = req_q;
    info_d = info_q;
    idx_d  = idx_q;
    left_d = left_q;
    wait_d = wait_q;
    ack_d  = 1'b0;
    wack_d = 1'b0;
    done_d = 1'b0;
    cyc    = '{1'b0, 1'b0, 1'b0, 8'h00};
    nxt_busy = (info_q.rd && left_q != 12'h000) ? ST_GAP : ST_DONE;
    nxt_cmd2 = info_q.addr2 ? ST_ADDR2 : info_q.waitb ? ST_WAITB : nxt_busy;
    nxt_addr = (info_q.wr && left_q != 12'h000) ? ST_GAP :
               info_q.has_cmd2 ? ST_CMD2 : info_q.waitb ? ST_WAITB : nxt_busy;
    case (st_q)
      ST_IDLE: if (req_valid && req_ready && acc_ok) begin
        req_d  = req;
        info_d = info_in;
        // Cap the transfer at PAGE_BYTES bytes, whatever the start column
        left_d = (req.len > PAGE_BYTES) ? PAGE_BYTES : req.len;
        idx_d  = 2'd0;
        ack_d  = 1'b1;
        st_d   = ST_CMD1;
      end
      ST_CMD1: begin
        cyc = '{1'b0, 1'b1, 1'b0, info_q.cmd1};
        if (bc_done) begin
          st_d = (info_q.ak != AK_NONE) ? ST_ADDR : nxt_addr;
        end
      end
      ST_ADDR: begin
        cyc.ale = 1'b1;
        case (idx_q)
          2'd0: cyc.data = (info_q.ak == AK_ROW2) ? row[7:0] :
                           (info_q.ak == AK_ONE) ? 8'h00 : req_q.col[7:0];
          2'd1: cyc.data = (info_q.ak == AK_ROW2) ? row[15:8] : {4'h0, req_q.col[11:8]};
          2'd2: cyc.data = row[7:0];
          default: cyc.data = row[15:8];
        endcase
        if (bc_done) begin
          idx_d = idx_q + 2'd1;
          if (idx_q == last_idx) begin
            idx_d = 2'd0;
            st_d  = nxt_addr;
          end
        end
      end
      ST_GAP: if (wait_q == 4'(T_ADL_CYC - 1)) begin
        wait_d = 4'h0;
        st_d   = info_q.wr ? ST_WDATA : ST_RDATA;
      end else begin
        wait_d = wait_q + 4'h1;
      end
      ST_WDATA: begin
        cyc.data = wr_data;
        if (bc_done) begin
          left_d = left_q - 12'h001;
          if (left_q == 12'h001) begin
            st_d = info_q.has_cmd2 ? ST_CMD2 : ST_DONE;
          end
        end
      end
      ST_CMD2: begin
        cyc = '{1'b0, 1'b1, 1'b0, info_q.cmd2};
        if (bc_done) begin
          st_d = nxt_cmd2;
        end
      end
      ST_ADDR2: begin
        cyc = '{1'b0, 1'b0, 1'b1, (idx_q == 2'd0) ? row_end[7:0] : row_end[15:8]};
        if (bc_done) begin
          idx_d = idx_q + 2'd1;
          if (idx_q == 2'd1) begin
            st_d = ST_DONE;
          end
        end
      end
      ST_WAITB: if (wait_q == 4'(T_WB_CYC - 1)) begin
        // Ready/busy needs time to fall after the last strobe
        wait_d = 4'h0;
        st_d   = ST_BUSY;
      end else begin
        wait_d = wait_q + 4'h1;
      end
      ST_BUSY: if (nand_rb) begin
        st_d = nxt_busy;
      end
      ST_RDATA: begin
        cyc.rd = 1'b1;
        if (bc_done) begin
          left_d = left_q - 12'h001;
          if (left_q == 12'h001) begin
            st_d = ST_DONE;
          end
        end
      end
      ST_DONE: begin
        done_d = 1'b1;
        st_d   = ST_IDLE;
      end
      default: st_d = ST_IDLE;
    endcase
    cyc_st = (st_q == ST_CMD1) || (st_q == ST_ADDR) || (st_q == ST_WDATA) ||
             (st_q == ST_CMD2) || (st_q == ST_ADDR2) || (st_q == ST_RDATA);
    start  = cyc_st && !pend_q && !(st_q == ST_WDATA && !wr_valid);
    wack_d = start && (st_q == ST_WDATA);
    pend_d = bc_done ? 1'b0 : (pend_q || start);
    rdy_d  = (st_d == ST_IDLE);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ST_IDLE;
      req_q <= '0;
      info_q <= '0;
      idx_q <= 2'd0;
      left_q <= 12'h000;
      wait_q <= 4'h0;
      pend_q <= 1'b0;
      req_ready <= 1'b0;
      req_ack <= 1'b0;
      wr_ack <= 1'b0;
      op_done <= 1'b0;
      nand_wp_n <= 1'b0;
    end else begin
      st_q <= st_d;
      req_q <= req_d;
      info_q <= info_d;
      idx_q <= idx_d;
      left_q <= left_d;
      wait_q <= wait_d;
      pend_q <= pend_d;
      req_ready <= rdy_d;
      req_ack <= ack_d;
      wr_ack <= wack_d;
      op_done <= done_d;
      // Write protect held only while in reset
      nand_wp_n <= 1'b1;
    end
  end

  ncad_bus_cycle u_bus (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .start         (start),
    .cyc           (cyc),
    .sel           (st_d != ST_IDLE),
    .nand_io_i     (nand_io_i),
    .nand_ce_n     (nand_ce_n),
    .nand_cle      (nand_cle),
    .nand_ale      (nand_ale),
    .nand_we_n     (nand_we_n),
    .read_strobe_n (read_strobe_n),
    .nand_io_o     (nand_io_o),
    .nand_io_oe    (nand_io_oe),
    .rd_data       (rd_data),
    .rd_valid      (rd_valid),
    .done          (bc_done)
  );

  // ==========================================================
  // Checks
  property p_row_block;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_ADDR && info_q.ak == AK_FULL && idx_q == 2'd3 && !nand_we_n)
      |-> nand_io_o == req_q.block[9:2];
  endproperty
  a_row_block: assert property (p_row_block) else $error("fourth address byte wrong");

  property p_col_hi;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_ADDR && idx_q == 2'd1 && info_q.ak inside {AK_FULL, AK_COL2} && !nand_we_n)
      |-> nand_io_o[7:4] == 4'h0;
  endproperty
  a_col_hi: assert property (p_col_hi) else $error("upper column lines not low");

  property p_we_ce;
    @(posedge clk) disable iff (sys_rst) !nand_we_n |-> !nand_ce_n && nand_io_oe;
  endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without select");

  property p_cmd1;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_CMD1 && !nand_we_n) |-> nand_cle && !nand_ale && nand_io_o == info_q.cmd1;
  endproperty
  a_cmd1: assert property (p_cmd1) else $error("setup command cycle wrong");

  property p_cmd2;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_CMD2 && !nand_we_n) |-> nand_cle && nand_io_o == info_q.cmd2;
  endproperty
  a_cmd2: assert property (p_cmd2) else $error("execution command cycle wrong");

  property p_exec_then_wait;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_CMD2 && bc_done && !info_q.addr2 && info_q.waitb) |=> st_q == ST_WAITB;
  endproperty
  a_exec_then_wait: assert property (p_exec_then_wait) else $error("no wait after execute");

  property p_refuse_busy;
    @(posedge clk) disable iff (sys_rst)
      (st_q == ST_IDLE && req_valid && !acc_ok) |=> st_q == ST_IDLE && !req_ack;
  endproperty
  a_refuse_busy: assert property (p_refuse_busy) else $error("command taken while busy");

  property p_busy_wait;
    @(posedge clk) disable iff (sys_rst)
      st_q == ST_BUSY |=> (st_q == ST_BUSY) == !$past(nand_rb);
  endproperty
  a_busy_wait: assert property (p_busy_wait) else $error("busy wait mismatch");

  property p_page_len;
    @(posedge clk) disable iff (sys_rst) st_q != ST_IDLE |-> left_q <= PAGE_BYTES;
  endproperty
  a_page_len: assert property (p_page_len) else $error("transfer longer than page");

  c_read:   cover property (@(posedge clk) st_q == ST_RDATA && bc_done && left_q == 12'h001);
  c_prog:   cover property (@(posedge clk) st_q == ST_BUSY && info_q.wr && nand_rb);
  c_refuse: cover property (@(posedge clk) st_q == ST_IDLE && req_valid && !acc_ok);

endmodule : ncad_host

// file: dv/ncad_dev_model.sv
// Behavioural NAND device on the far side of the host sequencer
`timescale 1ns/10ps
module ncad_dev_model
  import ncad_pkg::*;
#(
  parameter int         BUSY_NS = 500,
  parameter logic [7:0] STAT_OK = 8'hE0
)(
  input  wire logic       ce_n,
  input  wire logic       cle,
  input  wire logic       ale,
  input  wire logic       we_n,
  input  wire logic       rs_n,
  input  wire logic [7:0] din,
  input  wire logic       oe,
  input  wire logic       hold_busy,
  output logic      [7:0] dout,
  output logic            rb
);
  logic [7:0]  cmd_q;
  logic [7:0]  io_q;
  logic [7:0]  abuf [4];
  logic [2:0]  acnt;
  logic [11:0] col;
  logic        busy;
  logic [9:0]  log_q [$];

  initial begin
    busy  = 1'b0;
    io_q  = 8'h00;
    acnt  = 3'h0;
    col   = 12'h000;
    cmd_q = 8'h00;
  end

  assign rb   = ~(busy | hold_busy);
  assign dout = io_q;

  // ==========================================================
  // Byte capture
  always @(posedge we_n) begin
    if (!ce_n && oe) begin
      log_q.push_back({cle, ale, din});
      if (cle) begin
        cmd_q = din;
        acnt  = 3'h0;
        if (din inside {8'h30, 8'h35, 8'h10, 8'hD0, 8'h15, 8'h31, 8'h3F}) begin
          busy = 1'b1;
          busy <= #BUSY_NS 1'b0;
        end
      end else if (ale && acnt < 3'h4) begin
        abuf[acnt[1:0]] = din;
        acnt = acnt + 3'h1;
        if (acnt == 3'h2) col = {abuf[1][3:0], abuf[0]};
      end
    end
  end

  // ==========================================================
  // Read out; released bus shows inverted data so stale bytes never pass
  always @(negedge rs_n) begin
    if (!ce_n) begin
      io_q = (cmd_q inside {8'h70, 8'h7A}) ? STAT_OK : col[7:0];
      col  = col + 12'h001;
    end
  end
  always @(posedge rs_n) io_q = ~io_q;
endmodule : ncad_dev_model

// file: dv/tb_top.sv
// Self-checking bench for the NAND host sequencer
`timescale 1ns/10ps
module tb_top;
  import ncad_pkg::*;
  logic       clk, sys_rst, req_valid, wr_valid, hold_busy;
  ncad_req_s  req;
  logic [7:0] wr_data, rd_data, io_o, io_i;
  logic       req_ready, req_ack, wr_ack, rd_valid, op_done, rb;
  logic       ce_n, cle, ale, we_n, rs_n, wp_n, io_oe;
  int         err_count, check_count, cyc, wack_n;
  logic [7:0] rdq [$];

  ncad_host dut (.clk(clk), .sys_rst(sys_rst), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .req_ack(req_ack), .wr_data(wr_data), .wr_valid(wr_valid),
    .wr_ack(wr_ack), .rd_data(rd_data), .rd_valid(rd_valid), .op_done(op_done),
    .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .read_strobe_n(rs_n), .nand_wp_n(wp_n), .nand_io_o(io_o), .nand_io_oe(io_oe),
    .nand_io_i(io_i), .nand_rb(rb));

  ncad_dev_model u_dev (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .rs_n(rs_n),
    .din(io_o), .oe(io_oe), .hold_busy(hold_busy), .dout(io_i), .rb(rb));

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(negedge clk) if (rd_valid === 1'b1) rdq.push_back(rd_data);
  always @(negedge clk) if (wr_ack === 1'b1) wack_n++;

  task automatic summarize();
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end

  task automatic chk(input string name, input logic [9:0] seen, input logic [9:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic chk_log(input logic [9:0] exp [$]);
    chk("bus_count", 10'(u_dev.log_q.size()), 10'(exp.size()));
    foreach (exp[i]) chk("bus_byte", u_dev.log_q[i], exp[i]);
  endtask : chk_log

  task automatic run_op(input ncad_op_e op, input logic [11:0] c, input logic [9:0] b,
                        input logic [5:0] p, input logic [11:0] n);
    int k;
    u_dev.log_q.delete();
    rdq.delete();
    @(negedge clk);
    req = '{op, c, b, p, b, n};
    req_valid = 1'b1;
    k = 0;
    while (req_ack !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    req_valid = 1'b0;
    chk("ready_low", {9'h000, req_ready}, 10'h000);
    k = 0;
    while (op_done !== 1'b1 && k < 5000) begin
      @(negedge clk);
      k++;
    end
    chk("op_done", {9'h000, op_done}, 10'h001);
    chk("ce_n_idle", {9'h000, ce_n}, 10'h001);
    chk("ready_back", {9'h000, req_ready}, 10'h001);
  endtask : run_op

  // ==========================================================
  // Scenarios
  task automatic t_status();
    run_op(OP_STATUS, 12'h000, 10'h000, 6'h00, 12'h001);
    chk_log('{10'h270});
    chk("status", {2'b00, rdq[0]}, 10'h0E0);
  endtask : t_status

  task automatic t_read();
    // Spare-area start column, odd block/page bits to catch row packing slips
    run_op(OP_READ, 12'h801, 10'h155, 6'h2A, 12'h002);
    chk_log('{10'h200, 10'h101, 10'h108, 10'h16A, 10'h155, 10'h230});
    chk("rd0", {2'b00, rdq[0]}, 10'h001);
    chk("rd1", {2'b00, rdq[1]}, 10'h002);
    chk("rd_count", 10'(rdq.size()), 10'h002);
  endtask : t_read

  task automatic t_cache();
    // Column counter carries on from the page read
    run_op(OP_CACHE_READ, 12'h000, 10'h000, 6'h00, 12'h001);
    chk_log('{10'h231});
    chk("cache_rd", {2'b00, rdq[0]}, 10'h003);
  endtask : t_cache

  task automatic t_block();
    run_op(OP_UNLOCK, 12'h000, 10'h002, 6'h05, 12'h000);
    chk_log('{10'h223, 10'h185, 10'h100, 10'h224, 10'h180, 10'h100});
    run_op(OP_LOCK_STAT, 12'h000, 10'h002, 6'h05, 12'h001);
    chk_log('{10'h27A, 10'h185, 10'h100});
    chk("lock_stat", {2'b00, rdq[0]}, 10'h0E0);
  endtask : t_block

  task automatic t_prog();
    wr_data  = 8'h3C;
    wr_valid = 1'b1;
    wack_n   = 0;
    run_op(OP_PROG, 12'h000, 10'h3FF, 6'h3F, 12'h001);
    wr_valid = 1'b0;
    chk("wr_ack", 10'(wack_n), 10'h001);
    chk_log('{10'h280, 10'h100, 10'h100, 10'h1FF, 10'h1FF, 10'h03C, 10'h210});
  endtask : t_prog

  task automatic t_erase();
    run_op(OP_ERASE, 12'h000, 10'h001, 6'h00, 12'h000);
    chk_log('{10'h260, 10'h140, 10'h100, 10'h2D0});
  endtask : t_erase

  task automatic t_refuse();
    logic seen;
    seen = 1'b0;
    hold_busy = 1'b1;
    @(negedge clk);
    req = '{OP_ERASE, 12'h000, 10'h002, 6'h00, 10'h000, 12'h000};
    req_valid = 1'b1;
    repeat (20) begin
      @(negedge clk);
      if (req_ack === 1'b1) seen = 1'b1;
    end
    req_valid = 1'b0;
    chk("busy_refuse", {9'h000, seen}, 10'h000);
    run_op(OP_STATUS, 12'h000, 10'h000, 6'h00, 12'h001);
    chk_log('{10'h270});
    hold_busy = 1'b0;
  endtask : t_refuse

  initial begin
    err_count   = 0;
    check_count = 0;
    cyc         = 0;
    sys_rst     = 1'b1;
    req_valid   = 1'b0;
    req         = '0;
    wr_valid    = 1'b0;
    wr_data     = 8'h00;
    hold_busy   = 1'b0;
    repeat (5) @(posedge clk);
    @(negedge clk);
    sys_rst = 1'b0;
    repeat (2) @(negedge clk);
    chk("wp_n", {9'h000, wp_n}, 10'h001);
    t_status();
    t_read();
    t_cache();
    t_prog();
    t_erase();
    t_block();
    t_refuse();
    summarize();
  end
endmodule : tb_top
